// ==== src/dpgcd_ports.sv ====
// Module: pin groups C and D with peripheral override, parallel mode and Avalon-MM registers
`timescale 1ns/1ps

module dpgcd_ports #(
  parameter bit HAS_SERIAL = 1'b1, // Variant has the serial transceiver
  parameter bit HAS_SECOND_CAPTURE_COMPARE_PWM = 1'b1    // Variant has the second capture unit
) (
  input wire logic ref_clk, // Core clock, 250 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic porClear, // Power-on or brown-out reset seen, one-cycle pulse
  input wire dpgcd_pkg::dpgcd_avs_req_type avs, // Avalon-MM request
  output logic [31:0] avsReadData, // Avalon-MM read data
  output logic avsWaitRequest, // Avalon-MM waitrequest
  input wire logic [7:0] pinCIn, // Group C pin levels
  output logic [7:0] pinCOut, // Group C output data
  output logic [7:0] pinCOe, // Group C output enable, high drives
  input wire logic [7:0] pinDIn, // Group D pin levels
  output logic [7:0] pinDOut, // Group D output data
  output logic [7:0] pinDOe, // Group D output enable, high drives
  input wire dpgcd_pkg::dpgcd_periph_type periph, // Peripheral claims on group C
  output logic [7:0] periphCLevel, // Group C levels to the peripherals
  input wire dpgcd_pkg::dpgcd_psp_type parallel_slave_port, // Parallel slave port engine
  output logic [7:0] pspDLevel, // Group D levels to the engine
  output logic parallelMode, // Parallel mode select
  output logic [2:0] groupEDir // Group E direction bits
);

  // Output enable and data of one pin: peripheral when selected, else port
  function automatic logic [1:0] pinDrive(input logic sel, input logic oe, input logic out,
                                          input logic dir, input logic latch);
    logic [1:0] result;
    result = sel ? {oe, out} : {~dir, latch};
    return result;
  endfunction

  // Pins whose direction a peripheral currently overrides
  function automatic logic [7:0] enMask(input dpgcd_pkg::dpgcd_pin_map_type map);
    logic [7:0] mask;
    for (int i = 0; i < 8; i++)
    begin
      mask[i] = map[i].en;
    end
    return mask;
  endfunction

  // Accepts one register write when the low byte lane is enabled
  function automatic logic regWrite(input dpgcd_pkg::dpgcd_avs_req_type req, input logic wait_q,
                                    input logic [7:0] ofs);
    logic hit;
    hit = req.write && !wait_q && req.byteenable[0] && req.address == ofs;
    return hit;
  endfunction

  logic [7:0] latchC;
  logic [7:0] latchD;
  logic [7:0] dirC;
  logic [7:0] dirD;
  logic [2:0] dirE;
  logic ovfFlag;
  dpgcd_pkg::dpgcd_pin_map_type mapC;
  logic [7:0] effDirC;
  logic [7:0] next_pinCOe;
  logic [7:0] next_pinCOut;
  logic [7:0] next_pinDOe;
  logic [7:0] next_pinDOut;
  logic [31:0] next_readData;
  logic [7:0] eCtrl;
  logic busReq;

  assign busReq = avs.read || avs.write;

  // Route each peripheral to its pin; variant parameters drop absent units
  always_comb
  begin
    mapC = '0;
    mapC[dpgcd_pkg::PIN_TMR_OSC_OUT] = periph.tmrOscOut;
    mapC[dpgcd_pkg::PIN_TMR_OSC_IN] = periph.tmrOscIn;
    if (HAS_SECOND_CAPTURE_COMPARE_PWM && periph.second_capture_compare_pwm.en)
    begin
      mapC[dpgcd_pkg::PIN_SECOND_CAPTURE_COMPARE_PWM] = periph.second_capture_compare_pwm;
    end
    mapC[dpgcd_pkg::PIN_FIRST_CAPTURE_COMPARE_PWM] = periph.first_capture_compare_pwm;
    mapC[dpgcd_pkg::PIN_SSP_CLK] = periph.sspClk;
    mapC[dpgcd_pkg::PIN_SSP_DIN] = periph.sspDin;
    mapC[dpgcd_pkg::PIN_SSP_DOUT] = periph.sspDout;
    if (HAS_SERIAL)
    begin
      mapC[dpgcd_pkg::PIN_SER_TX] = periph.serTx;
      mapC[dpgcd_pkg::PIN_SER_RX] = periph.serRx;
    end
  end

  // Effective direction; software reads this back, so bit operations lose overrides
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      effDirC[i] = mapC[i].en ? mapC[i].forceIn : dirC[i];
    end
  end

  // Next pin drive of both groups
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      {next_pinCOe[i], next_pinCOut[i]} = pinDrive(mapC[i].sel, mapC[i].oe, mapC[i].out,
                                                    effDirC[i], latchC[i]);
      {next_pinDOe[i], next_pinDOut[i]} = pinDrive(parallelMode, parallel_slave_port.parOe, parallel_slave_port.parOut[i],
                                                    dirD[i], latchD[i]);
    end
  end

  // Group C and D pin drivers, registered so the pads see clean edges
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinCOe <= 8'h00;
      pinCOut <= 8'h00;
      pinDOe <= 8'h00;
      pinDOut <= 8'h00;
    end
    else
    begin
      pinCOe <= next_pinCOe;
      pinCOut <= next_pinCOut & next_pinCOe;
      pinDOe <= next_pinDOe;
      pinDOut <= next_pinDOut & next_pinDOe;
    end
  end

  // Pin levels to peripherals and to the parallel engine
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      periphCLevel <= 8'h00;
      pspDLevel <= 8'h00;
    end
    else
    begin
      periphCLevel <= pinCIn;
      pspDLevel <= pinDIn;
    end
  end

  // Data latches keep their value across ordinary resets; only porClear (power-on or brown-out) clears them
  always_ff @(posedge ref_clk)
  begin
    if (porClear)
    begin
      latchC <= dpgcd_pkg::RST_LATCH_POR;
      latchD <= dpgcd_pkg::RST_LATCH_POR;
    end
    else
    begin
      if (regWrite(avs, avsWaitRequest, dpgcd_pkg::OFS_C_LATCH))
      begin
        latchC <= avs.writedata[7:0];
      end
      if (regWrite(avs, avsWaitRequest, dpgcd_pkg::OFS_D_LATCH))
      begin
        latchD <= avs.writedata[7:0];
      end
    end
  end

  // Direction registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dirC <= dpgcd_pkg::RST_C_DIR;
      dirD <= dpgcd_pkg::RST_D_DIR;
    end
    else
    begin
      if (regWrite(avs, avsWaitRequest, dpgcd_pkg::OFS_C_DIR))
      begin
        dirC <= avs.writedata[7:0];
      end
      if (regWrite(avs, avsWaitRequest, dpgcd_pkg::OFS_D_DIR))
      begin
        dirD <= avs.writedata[7:0];
      end
    end
  end

  // Group E control; software must leave E pins as inputs in parallel mode
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dirE <= dpgcd_pkg::RST_E_CTRL[dpgcd_pkg::E_DIR_MSB:0];
      parallelMode <= dpgcd_pkg::RST_E_CTRL[dpgcd_pkg::E_PAR_MODE_BIT];
    end
    else if (regWrite(avs, avsWaitRequest, dpgcd_pkg::OFS_E_CTRL))
    begin
      dirE <= avs.writedata[dpgcd_pkg::E_DIR_MSB:0];
      parallelMode <= avs.writedata[dpgcd_pkg::E_PAR_MODE_BIT];
    end
  end

  // Overflow flag: engine sets, software writes zero; a set in the clear cycle wins
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ovfFlag <= dpgcd_pkg::RST_E_CTRL[dpgcd_pkg::E_OVF_BIT];
    end
    else if (parallel_slave_port.ovfEvent)
    begin
      ovfFlag <= 1'b1;
    end
    else if (regWrite(avs, avsWaitRequest, dpgcd_pkg::OFS_E_CTRL))
    begin
      ovfFlag <= avs.writedata[dpgcd_pkg::E_OVF_BIT];
    end
  end

  // Group E direction copy for the pads outside this block
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      groupEDir <= dpgcd_pkg::RST_E_CTRL[dpgcd_pkg::E_DIR_MSB:0];
    end
    else
    begin
      groupEDir <= dirE;
    end
  end

  // Control register image; bit 3 is unimplemented and reads zero
  always_comb
  begin
    eCtrl = 8'h00;
    eCtrl[dpgcd_pkg::E_IN_FULL_BIT] = parallel_slave_port.inFull;
    eCtrl[dpgcd_pkg::E_OUT_FULL_BIT] = parallel_slave_port.outFull;
    eCtrl[dpgcd_pkg::E_OVF_BIT] = ovfFlag;
    eCtrl[dpgcd_pkg::E_PAR_MODE_BIT] = parallelMode;
    eCtrl[dpgcd_pkg::E_DIR_MSB:0] = dirE;
  end

  // Read multiplexer; data registers read the pins, unmapped reads give zero
  always_comb
  begin
    next_readData = 32'h0000_0000;
    case (avs.address)
      dpgcd_pkg::OFS_C_LATCH: next_readData[7:0] = pinCIn;
      dpgcd_pkg::OFS_D_LATCH: next_readData[7:0] = pinDIn;
      dpgcd_pkg::OFS_C_DIR: next_readData[7:0] = effDirC;
      dpgcd_pkg::OFS_D_DIR: next_readData[7:0] = dirD;
      dpgcd_pkg::OFS_E_CTRL: next_readData[7:0] = eCtrl;
      default: next_readData = 32'h0000_0000;
    endcase
  end

  // Bus answer: one wait cycle, then waitrequest low for exactly one cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avsWaitRequest <= 1'b1;
      avsReadData <= 32'h0000_0000;
    end
    else
    begin
      avsWaitRequest <= !(busReq && avsWaitRequest);
      if (avs.read && avsWaitRequest)
      begin
        avsReadData <= next_readData;
      end
    end
  end

  // Helper: C direction written by software since reset
  logic dirCTouched;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dirCTouched <= 1'b0;
    end
    else if (regWrite(avs, avsWaitRequest, dpgcd_pkg::OFS_C_DIR))
    begin
      dirCTouched <= 1'b1;
    end
  end

  sequence seqCReadTaken;
    avs.read && avsWaitRequest && avs.address == dpgcd_pkg::OFS_C_LATCH;
  endsequence

  sequence seqCDirWrite;
    regWrite(avs, avsWaitRequest, dpgcd_pkg::OFS_C_DIR);
  endsequence

  AST_C_DIR_RESET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !dirCTouched |-> dirC == 8'hFF && (effDirC | enMask(mapC)) == 8'hFF)
    else $error("C direction not all ones before first write");

  AST_C_DIR_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    seqCDirWrite |=> dirC == $past(avs.writedata[7:0]))
    else $error("C direction write lost");

  AST_OVERRIDE_IN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mapC[7].en && mapC[7].forceIn && !mapC[7].sel |=> !pinCOe[7])
    else $error("Peripheral input override ignored");

  AST_OVERRIDE_RELEASE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(mapC[7].en) && !mapC[7].sel && !dirC[7] |=> pinCOe[7])
    else $error("Direction not restored after peripheral disable");

  AST_SEL_DATA: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mapC[5].sel && mapC[5].oe |=> pinCOut[5] == $past(mapC[5].out))
    else $error("Selected peripheral data not on pin");

  AST_OE_IGNORED: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !mapC[2].sel && mapC[2].oe && effDirC[2] |=> !pinCOe[2])
    else $error("Unselected peripheral enable honoured");

  AST_PAR_MODE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    parallelMode && parallel_slave_port.parOe |=> pinDOe == 8'hFF && pinDOut == $past(parallel_slave_port.parOut))
    else $error("Parallel data not on group D");

  AST_D_HIZ: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dirD[0] && !parallelMode ##1 dirD[0] |-> !pinDOe[0])
    else $error("Group D pin driven while direction is input");

  AST_READ_PIN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    seqCReadTaken |=> !avsWaitRequest && avsReadData == {24'h000000, $past(pinCIn)})
    else $error("C data read does not return pin levels");

  AST_E_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
    avs.read && avsWaitRequest && avs.address == dpgcd_pkg::OFS_E_CTRL |=> avsReadData[31:8] == 24'h000000
      && !avsReadData[dpgcd_pkg::E_ZERO_BIT])
    else $error("Control register unimplemented bits not zero");

endmodule

// ==== src/dpgcd_pkg.sv ====
// Package: register map, field positions, pin routing and carrier types of the C/D pin groups
package dpgcd_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] OFS_C_LATCH = 8'h07;
  localparam logic [7:0] OFS_D_LATCH = 8'h08;
  localparam logic [7:0] OFS_C_DIR = 8'h87;
  localparam logic [7:0] OFS_D_DIR = 8'h88;
  localparam logic [7:0] OFS_E_CTRL = 8'h89;

  // Reset values
  localparam logic [7:0] RST_C_DIR = 8'hFF;
  localparam logic [7:0] RST_D_DIR = 8'hFF;
  localparam logic [7:0] RST_E_CTRL = 8'h07;
  localparam logic [7:0] RST_LATCH_POR = 8'h00;

  // Group E control field positions
  localparam int E_IN_FULL_BIT = 7;
  localparam int E_OUT_FULL_BIT = 6;
  localparam int E_OVF_BIT = 5;
  localparam int E_PAR_MODE_BIT = 4;
  localparam int E_ZERO_BIT = 3;
  localparam int E_DIR_MSB = 2;

  // Group C pin routing of the on-chip peripherals
  localparam int PIN_TMR_OSC_OUT = 0;
  localparam int PIN_TMR_OSC_IN = 1;
  localparam int PIN_SECOND_CAPTURE_COMPARE_PWM = 1;
  localparam int PIN_FIRST_CAPTURE_COMPARE_PWM = 2;
  localparam int PIN_SSP_CLK = 3;
  localparam int PIN_SSP_DIN = 4;
  localparam int PIN_SSP_DOUT = 5;
  localparam int PIN_SER_TX = 6;
  localparam int PIN_SER_RX = 7;

  // One peripheral's claim on a pin
  typedef struct packed {
    logic en;      // Peripheral enabled, direction overridden
    logic forceIn; // Override direction: 1 input, 0 output
    logic sel;     // Port/peripheral select
    logic oe;      // Peripheral output enable
    logic out;     // Peripheral output data
  } dpgcd_pin_ctl_type;

  typedef dpgcd_pin_ctl_type [7:0] dpgcd_pin_map_type;

  // All peripherals that can take a group C pin
  typedef struct packed {
    dpgcd_pin_ctl_type tmrOscOut;
    dpgcd_pin_ctl_type tmrOscIn;
    dpgcd_pin_ctl_type first_capture_compare_pwm;
    dpgcd_pin_ctl_type second_capture_compare_pwm;
    dpgcd_pin_ctl_type sspClk;
    dpgcd_pin_ctl_type sspDin;
    dpgcd_pin_ctl_type sspDout;
    dpgcd_pin_ctl_type serTx;
    dpgcd_pin_ctl_type serRx;
  } dpgcd_periph_type;

  // Parallel slave port engine signals facing group D
  typedef struct packed {
    logic parOe;       // Engine drives group D
    logic [7:0] parOut; // Engine output data
    logic inFull;      // Input full status
    logic outFull;     // Output full status
    logic ovfEvent;    // One-cycle input overflow event
  } dpgcd_psp_type;

  // Avalon-MM request
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } dpgcd_avs_req_type;

endpackage

// ==== bench/dpgcd_pin_model.sv ====
// Board model: resolves group C and D pin levels from device and board drivers
`timescale 1ns/1ps
module dpgcd_pin_model (
  input wire logic [7:0] cOut, // Device group C data
  input wire logic [7:0] cOe, // Device group C enable
  input wire logic [7:0] cExt, // Board group C data
  input wire logic [7:0] cExtOe, // Board group C enable
  input wire logic [7:0] dOut, // Device group D data
  input wire logic [7:0] dOe, // Device group D enable
  input wire logic [7:0] dExt, // Board group D data
  input wire logic [7:0] dExtOe, // Board group D enable
  output logic [7:0] cLevel, // Resolved group C pins
  output logic [7:0] dLevel // Resolved group D pins
);
  // Pull-ups hold undriven pins high; two drivers fight to X so contention is seen
  function automatic logic [7:0] resolve(input logic [7:0] dv, input logic [7:0] de,
                                         input logic [7:0] ev, input logic [7:0] ee);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
      r[i] = (de[i] & ee[i]) ? 1'bx : de[i] ? dv[i] : ee[i] ? ev[i] : 1'b1;
    return r;
  endfunction

  // Pins settle combinationally
  assign cLevel = resolve(cOut, cOe, cExt, cExtOe);
  assign dLevel = resolve(dOut, dOe, dExt, dExtOe);
endmodule

// ==== bench/tb_top.sv ====
// Testbench: registers, pin direction, peripheral takeover and parallel mode of the C/D groups
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic porClear = 1'b0;
  dpgcd_pkg::dpgcd_avs_req_type avs = '0;
  dpgcd_pkg::dpgcd_periph_type periph = '0;
  dpgcd_pkg::dpgcd_psp_type parallel_slave_port = '0;
  logic [7:0] cExt = 8'h00;
  logic [7:0] cExtOe = 8'h00;
  logic [7:0] dExtOe = 8'h00;
  logic [31:0] avsReadData;
  logic avsWaitRequest;
  logic [7:0] pinCIn, pinCOut, pinCOe, pinDIn, pinDOut, pinDOe, periphCLevel, pspDLevel;
  logic parallelMode;
  logic [2:0] groupEDir;
  logic [7:0] rd;
  int errTotal = 0;
  int nCompared = 0;
  int pinOf [9] = '{0, 1, 2, 1, 3, 4, 5, 6, 7};

  // 250 MHz core clock
  always #2 ref_clk = ~ref_clk;

  dpgcd_ports i_dpgcd_ports (.ref_clk(ref_clk), .rst_n(rst_n), .porClear(porClear), .avs(avs),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .pinCIn(pinCIn), .pinCOut(pinCOut),
    .pinCOe(pinCOe), .pinDIn(pinDIn), .pinDOut(pinDOut), .pinDOe(pinDOe), .periph(periph),
    .periphCLevel(periphCLevel), .parallel_slave_port(parallel_slave_port), .pspDLevel(pspDLevel), .parallelMode(parallelMode),
    .groupEDir(groupEDir));

  dpgcd_pin_model i_dpgcd_pin_model (.cOut(pinCOut), .cOe(pinCOe), .cExt(cExt), .cExtOe(cExtOe),
    .dOut(pinDOut), .dOe(pinDOe), .dExt(8'h00), .dExtOe(dExtOe), .cLevel(pinCIn), .dLevel(pinDIn));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      errTotal++;
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One Avalon transfer: request after an edge, held until the edge that samples waitrequest low
  task automatic bus(input logic [7:0] a, input logic wr, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs.address <= a;
    avs.read <= ~wr;
    avs.write <= wr;
    avs.writedata <= {24'h0, d};
    avs.byteenable <= 4'hF;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avsWaitRequest !== 1'b0 && n < 40);
    if (avsWaitRequest !== 1'b0)
    begin
      errTotal++;
      end_of_test();
    end
    rd = avsReadData[7:0];
    avs.read <= 1'b0;
    avs.write <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    bus(a, 1'b0, 8'h00);
    chk(rd, exp);
  endtask

  // Outputs are registered one cycle behind their causes
  task automatic settle();
    repeat (2) @(negedge ref_clk);
  endtask

  // Main sequence; whole-byte writes only, never bit operations on the C direction
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    porClear <= 1'b1;
    @(posedge ref_clk);
    porClear <= 1'b0;
    rchk(8'h87, 8'hFF);
    rchk(8'h88, 8'hFF);
    rchk(8'h89, 8'h07);
    @(negedge ref_clk);
    chk(pinCOe, 8'h00);
    chk(pinDOe, 8'h00);
    chk({5'h00, groupEDir}, 8'h07);
    $display("test reset done");
    bus(8'h87, 1'b1, 8'hF0);
    settle();
    chk(pinCOe, 8'h0F);
    chk(pinCOut, 8'h00);
    bus(8'h07, 1'b1, 8'hA5);
    cExt <= 8'h3C;
    cExtOe <= 8'hF0;
    settle();
    chk(pinCOut, 8'h05);
    rchk(8'h07, 8'h35);
    @(negedge ref_clk);
    chk(periphCLevel, 8'h35);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    cExtOe <= 8'h00;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rchk(8'h87, 8'hFF);
    bus(8'h87, 1'b1, 8'h00);
    settle();
    chk(pinCOut, 8'hA5);
    $display("test latch done");
    bus(8'h87, 1'b1, 8'hFF);
    for (int k = 0; k < 9; k++)
    begin
      @(posedge ref_clk);
      periph[44 - 5 * k -: 5] <= 5'b10111;
      settle();
      chk(pinCOe, 8'h01 << pinOf[k]);
      chk(pinCOut, 8'h01 << pinOf[k]);
      rchk(8'h87, ~(8'h01 << pinOf[k]));
      @(posedge ref_clk);
      periph[44 - 5 * k -: 5] <= 5'b00011;
      settle();
      chk(pinCOe, 8'h00);
      @(posedge ref_clk);
      periph[44 - 5 * k -: 5] <= 5'b00000;
      settle();
      rchk(8'h87, 8'hFF);
    end
    bus(8'h87, 1'b1, 8'h00);
    periph[4:0] <= 5'b11000;
    settle();
    chk(pinCOe, 8'h7F);
    rchk(8'h87, 8'h80);
    periph[4:0] <= 5'b00000;
    settle();
    chk(pinCOe, 8'hFF);
    $display("test peripheral done");
    bus(8'h08, 1'b1, 8'h3C);
    bus(8'h88, 1'b1, 8'h00);
    settle();
    chk(pinDOe, 8'hFF);
    chk(pinDOut, 8'h3C);
    rchk(8'h08, 8'h3C);
    chk(pspDLevel, 8'h3C);
    bus(8'h89, 1'b1, 8'h17);
    parallel_slave_port.parOe <= 1'b1;
    parallel_slave_port.parOut <= 8'h81;
    parallel_slave_port.inFull <= 1'b1;
    parallel_slave_port.outFull <= 1'b1;
    parallel_slave_port.ovfEvent <= 1'b1;
    @(posedge ref_clk);
    parallel_slave_port.ovfEvent <= 1'b0;
    settle();
    chk({7'h00, parallelMode}, 8'h01);
    chk(pinDOut, 8'h81);
    rchk(8'h89, 8'hF7);
    bus(8'h89, 1'b1, 8'h0F);
    settle();
    rchk(8'h89, 8'hC7);
    chk(pinDOut, 8'h3C);
    bus(8'h10, 1'b1, 8'hFF);
    rchk(8'h10, 8'h00);
    $display("test group D done");
    end_of_test();
  end
endmodule
